// >>> design/cdc_pkg.sv
// constants and types for the carrier driver control block
package cdc_pkg;
    localparam logic [7:0] CDC_OFS_CONTROL = 8'h00;
    localparam logic [7:0] CDC_OFS_STEADY = 8'h04;
    localparam logic [7:0] CDC_OFS_MOD = 8'h08;
    localparam logic [7:0] CDC_OFS_STATUS = 8'h0C;
    localparam int CDC_BIT_A_EN = 0;
    localparam int CDC_BIT_B_EN = 1;
    localparam int CDC_BIT_ASK = 2;
    localparam int CDC_BIT_CW = 3;
    localparam int CDC_BIT_INV = 4;
    localparam int CDC_GS_W = 6;
    localparam logic [4:0] CDC_CTRL_RESET = 5'h00;
    localparam logic [5:0] CDC_STEADY_RESET = 6'h3F;
    localparam logic [5:0] CDC_MOD_RESET = 6'h3F;
    localparam logic [15:0] CDC_MOD_DEPTH_RESET = 16'h0001;
    localparam int CDC_CLK_HZ = 50000000;
    localparam int CDC_CARRIER_HZ = 13560000;
    // phase accumulator step for the carrier, 32-bit fraction of a cycle
    localparam logic [31:0] CDC_PHASE_STEP =
        32'((64'(CDC_CARRIER_HZ) << 32) / 64'(CDC_CLK_HZ));

    typedef struct packed {
        logic drive_b_invert;
        logic drive_b_continuous_wave;
        logic force_full_ask;
        logic drive_b_rf_enable;
        logic drive_a_rf_enable;
    } cdc_ctrl_t;

    typedef enum logic [2:0] {
        CDC_OUT_LOW = 3'h0,
        CDC_OUT_CARRIER = 3'h1,
        CDC_OUT_MOD = 3'h3,
        CDC_OUT_HIGH = 3'h2,
        CDC_OUT_INV = 3'h6,
        CDC_OUT_MOD_INV = 3'h7
    } cdc_out_t;
endpackage

// >>> design/cdc_select.sv
// per-pin output mode selection from control bits and envelope
module cdc_select
    import cdc_pkg::*;
(
    input wire cdc_ctrl_t ctrl,
    input wire logic envelope,
    output cdc_out_t mode_a,
    output cdc_out_t mode_b
);
    always_comb begin
        if (!ctrl.drive_a_rf_enable) begin
            mode_a = CDC_OUT_LOW;
        end else if (ctrl.force_full_ask) begin
            mode_a = envelope ? CDC_OUT_CARRIER : CDC_OUT_LOW;
        end else begin
            mode_a = envelope ? CDC_OUT_CARRIER : CDC_OUT_MOD;
        end
    end

    always_comb begin
        if (!ctrl.drive_b_rf_enable) begin
            mode_b = CDC_OUT_LOW;
        end else if (ctrl.drive_b_continuous_wave) begin
            mode_b = ctrl.drive_b_invert ? CDC_OUT_INV : CDC_OUT_CARRIER;
        end else if (ctrl.force_full_ask) begin
            if (envelope) begin
                mode_b = ctrl.drive_b_invert ? CDC_OUT_INV : CDC_OUT_CARRIER;
            end else begin
                mode_b = ctrl.drive_b_invert ? CDC_OUT_HIGH : CDC_OUT_LOW;
            end
        end else if (envelope) begin
            mode_b = ctrl.drive_b_invert ? CDC_OUT_INV : CDC_OUT_CARRIER;
        end else begin
            mode_b = ctrl.drive_b_invert ? CDC_OUT_MOD_INV : CDC_OUT_MOD;
        end
    end
endmodule // cdc_select

// >>> design/cdc_top.sv
// carrier driver control: ahb-lite registers, carrier generator, pin drive
module cdc_top
    import cdc_pkg::*;
#(
    parameter int ACC_W = 32
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic envelope,
    output logic antenna_drive_a,
    output logic antenna_drive_b,
    output logic [5:0] conductance,
    output logic modulation_phase
);
    cdc_ctrl_t driver_control_reg;
    logic [CDC_GS_W-1:0] steady_conductance_reg;
    logic [CDC_GS_W-1:0] modulation_conductance_reg;
    logic [15:0] mod_depth_reg;
    logic [ACC_W-1:0] phase_reg;
    logic wr_pend_reg;
    logic [7:0] wr_addr_reg;
    logic [31:0] hrdata_next;
    logic carrier;
    logic mod_gate_reg;
    logic [15:0] mod_cnt_reg;
    cdc_out_t mode_a;
    cdc_out_t mode_b;
    logic level_a;
    logic level_b;
    logic mod_any;
    logic [ACC_W-1:0] phase_next;
    logic carrier_rise;

    // bus: zero wait states, always okay
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_reg <= 1'b0;
            wr_addr_reg <= 8'h00;
        end else if (hready) begin
            wr_pend_reg <= hsel && htrans[1] && hwrite;
            wr_addr_reg <= haddr[7:0];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            driver_control_reg <= CDC_CTRL_RESET;
            steady_conductance_reg <= CDC_STEADY_RESET;
            modulation_conductance_reg <= CDC_MOD_RESET;
            mod_depth_reg <= CDC_MOD_DEPTH_RESET;
        end else if (wr_pend_reg) begin
            unique case (wr_addr_reg)
                CDC_OFS_CONTROL: begin
                    driver_control_reg <= cdc_ctrl_t'(hwdata[4:0]);
                    mod_depth_reg <= hwdata[31:16];
                end
                CDC_OFS_STEADY: steady_conductance_reg <= hwdata[CDC_GS_W-1:0];
                CDC_OFS_MOD: modulation_conductance_reg <= hwdata[CDC_GS_W-1:0];
                default: ;
            endcase
        end
    end

    // read mux, registered in the address phase
    always_comb begin
        hrdata_next = 32'h00000000;
        unique case (haddr[7:0])
            CDC_OFS_CONTROL: hrdata_next = {mod_depth_reg, 11'h000, driver_control_reg};
            CDC_OFS_STEADY: hrdata_next = {26'h0000000, steady_conductance_reg};
            CDC_OFS_MOD: hrdata_next = {26'h0000000, modulation_conductance_reg};
            CDC_OFS_STATUS: hrdata_next = {26'h0000000, mod_any, antenna_drive_b,
                antenna_drive_a, mode_b == CDC_OUT_LOW, envelope, carrier};
            default: hrdata_next = 32'h00000000;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h00000000;
        end else if (hready && hsel && htrans[1] && !hwrite) begin
            hrdata <= hrdata_next;
        end
    end

    // carrier from a phase accumulator; clock stands in for oscillator_input_pin
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            phase_reg <= '0;
        end else begin
            phase_reg <= phase_next;
        end
    end
    assign phase_next = phase_reg + ACC_W'(CDC_PHASE_STEP);
    assign carrier_rise = !phase_reg[ACC_W-1] && phase_next[ACC_W-1];
    assign carrier = phase_reg[ACC_W-1];

    // modulated carrier: carrier gated one period in every mod_depth+1
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            mod_cnt_reg <= 16'h0000;
            mod_gate_reg <= 1'b0;
        end else if (carrier_rise) begin
            if (mod_cnt_reg >= mod_depth_reg) begin
                mod_cnt_reg <= 16'h0000;
                mod_gate_reg <= 1'b1;
            end else begin
                mod_cnt_reg <= mod_cnt_reg + 16'h0001;
                mod_gate_reg <= 1'b0;
            end
        end
    end

    cdc_select u_select (
        .ctrl(driver_control_reg),
        .envelope(envelope),
        .mode_a(mode_a),
        .mode_b(mode_b)
    );

    function automatic logic pin_level(cdc_out_t m, logic c, logic g);
        logic r;
        r = 1'b0;
        unique case (m)
            CDC_OUT_LOW: r = 1'b0;
            CDC_OUT_HIGH: r = 1'b1;
            CDC_OUT_CARRIER: r = c;
            CDC_OUT_INV: r = !c;
            CDC_OUT_MOD: r = c && g;
            CDC_OUT_MOD_INV: r = !c && g;
            default: r = 1'b0;
        endcase
        return r;
    endfunction

    assign level_a = pin_level(mode_a, carrier, mod_gate_reg);
    assign level_b = pin_level(mode_b, carrier, mod_gate_reg);
    assign mod_any = (mode_a == CDC_OUT_MOD) || (mode_b == CDC_OUT_MOD)
        || (mode_b == CDC_OUT_MOD_INV);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            antenna_drive_a <= 1'b0;
            antenna_drive_b <= 1'b0;
        end else begin
            antenna_drive_a <= level_a;
            antenna_drive_b <= level_b;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            conductance <= CDC_STEADY_RESET;
            modulation_phase <= 1'b0;
        end else begin
            modulation_phase <= mod_any;
            conductance <= mod_any ? modulation_conductance_reg
                : steady_conductance_reg;
        end
    end
endmodule // cdc_top

// >>> test/cdc_top_monitor.sv
// checker for carrier driver control pins
module cdc_top_monitor
    import cdc_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [31:0] hwdata,
    input wire logic envelope,
    input wire logic antenna_drive_a,
    input wire logic antenna_drive_b,
    input wire logic [5:0] conductance,
    input wire logic modulation_phase
);
    timeunit 1ns;
    timeprecision 1ns;
    logic wa, ep, st, ae, be, ak, cw, iv, pa, pb;
    logic [7:0] ad;
    logic [16:0] sh, sp;
    logic [5:0] gs, gm;
    assign {iv, cw, ak, be, ae, gs, gm} = sp;
    assign st = sh == sp && envelope == ep;
    assign {pa, pb} = {antenna_drive_a, antenna_drive_b};
    // shadow of register writes
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            {wa, ep, ad, sh, sp} <= {10'h000, 17'h00FFF, 17'h00FFF};
        end else begin
            {wa, ep, ad, sp} <= {hsel && htrans[1] && hwrite, envelope, haddr[7:0], sh};
            if (wa && ad == CDC_OFS_CONTROL) sh[16:12] <= hwdata[4:0];
            if (wa && ad == CDC_OFS_STEADY) sh[11:6] <= hwdata[5:0];
            if (wa && ad == CDC_OFS_MOD) sh[5:0] <= hwdata[5:0];
        end
    end
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    property p_a_off; st && !ae |-> !pa; endproperty
    a_a_off: assert property (p_a_off) else $error("pin a not low");
    property p_b_off; st && !be |-> !pb; endproperty
    a_b_off: assert property (p_b_off) else $error("pin b not low");
    property p_b_inv; st && ae && be && ep && !ak && !cw |-> pb == (pa ^ iv); endproperty
    a_b_inv: assert property (p_b_inv) else $error("pin b phase");
    property p_b_cw; st && ae && be && ep && cw |-> pb == (pa ^ iv); endproperty
    a_b_cw: assert property (p_b_cw) else $error("pin b steady");
    property p_b_ask; st && be && ak && !cw && !ep |-> pb == iv; endproperty
    a_b_ask: assert property (p_b_ask) else $error("pin b level");
    property p_mod; st && ae && !ak && !ep |-> modulation_phase; endproperty
    a_mod: assert property (p_mod) else $error("no mod phase");
    property p_gs; st && !modulation_phase |-> conductance == gs; endproperty
    a_gs: assert property (p_gs) else $error("steady value");
    property p_gm; st && modulation_phase |-> conductance == gm; endproperty
    a_gm: assert property (p_gm) else $error("mod value");
endmodule // cdc_top_monitor
bind cdc_top cdc_top_monitor cdc_top_monitor_i (.hclk, .hresetn, .hsel, .haddr, .htrans,
    .hwrite, .hwdata, .envelope, .antenna_drive_a, .antenna_drive_b, .conductance,
    .modulation_phase);

// >>> test/cdc_antenna.sv
// antenna network model counting pin transitions
module cdc_antenna (
    input wire logic hclk,
    input wire logic drv_a,
    input wire logic drv_b,
    output int tog_a,
    output int tog_b
);
    timeunit 1ns;
    timeprecision 1ns;
    logic la = 1'b0, lb = 1'b0;
    int ca = 0, cb = 0;
    assign tog_a = ca;
    assign tog_b = cb;
    always @(posedge hclk) begin
        ca += 32'(drv_a !== la);
        cb += 32'(drv_b !== lb);
        {la, lb} = {drv_a, drv_b};
    end
endmodule // cdc_antenna

// >>> test/carrier_driver_control_test.sv
// self-checking bench for carrier driver control
module carrier_driver_control_test
    import cdc_pkg::*;
();
    timeunit 1ns;
    timeprecision 1ns;
    logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, envelope = 1'b1;
    logic [1:0] htrans = 2'h0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, q;
    logic hreadyout, pa, pb, mp;
    logic [5:0] cond;
    logic [23:0] r;
    int tog_a, tog_b, ta, tb, num_errors = 0, checks_done = 0, cyc = 0;
    // control, envelope, pin a kind, pin b kind, mod phase
    logic [23:0] rows [14] = '{24'h000000, 24'h051200, 24'h050000, 24'h031230, 24'h131250,
        24'h030431, 24'h0B0421, 24'h1F0020, 24'h070000, 24'h170010, 24'h171250, 24'h1B1250,
        24'h061020, 24'h130461};
    cdc_top cdc_top_i (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
        .hready(hreadyout), .hrdata, .hreadyout, .hresp(), .envelope, .antenna_drive_a(pa),
        .antenna_drive_b(pb), .conductance(cond), .modulation_phase(mp));
    cdc_antenna cdc_antenna_i (.hclk, .drv_a(pa), .drv_b(pb), .tog_a, .tog_b);
    initial forever #10 hclk = ~hclk;
    task automatic give_verdict();
        $display("checks %0d errors %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        checks_done++;
        if (s !== e) begin
            num_errors++;
            $display("[ERR] %0t seen %h expected %h", $time, s, e);
        end
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        {hsel, htrans, hwrite, haddr} <= {3'h6, w, 24'h0, a};
        do @(posedge hclk); while (hreadyout !== 1'b1);
        {hsel, htrans, hwrite, hwdata} <= {4'h0, d};
        do @(posedge hclk); while (hreadyout !== 1'b1);
        q = hrdata;
    endtask
    always @(posedge hclk) begin
        cyc++;
        if (cyc == 5000) begin
            num_errors++;
            give_verdict();
        end
    end
    initial begin
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        bus(1'b1, CDC_OFS_STEADY, 32'h15);
        bus(1'b1, CDC_OFS_MOD, 32'h2A);
        for (int i = 0; i < 14; i++) begin
            r = rows[i];
            @(posedge hclk);
            bus(1'b1, CDC_OFS_CONTROL, {16'h0001, 8'h00, r[23:16]});
            envelope <= r[12];
            repeat (4) @(negedge hclk);
            {ta, tb} = {tog_a, tog_b};
            repeat (16) begin
                @(negedge hclk);
                if (r[11:8] == 4'h0) chk(32'(pa), 32'h0);
                if (r[7:4] < 4'h2) chk(32'(pb), 32'(r[4]));
                if (r[7:4] == 4'h3) chk(32'(pb), 32'(pa));
                if (r[7:4] == 4'h5) chk(32'(pb), 32'(!pa));
                if (r[7:4] == 4'h6) chk(32'(pa && pb), 32'h0);
                chk(32'(mp), 32'(r[0]));
                chk(32'(cond), r[0] ? 32'h2A : 32'h15);
            end
            if (r[11:8] == 4'h2) chk(32'(tog_a > ta), 32'h1);
            if (r[11:8] == 4'h4) chk(32'(tog_a > ta), 32'h1);
            if (r[11:8] == 4'h4 && r[7:4] == 4'h2)
                chk(32'(tog_a - ta < tog_b - tb), 32'h1);
            if (r[7:4] == 4'h2) chk(32'(tog_b > tb), 32'h1);
            if (r[7:4] == 4'h6) chk(32'(tog_b > tb), 32'h1);
            $display("row %0d done", i);
        end
        @(posedge hclk);
        hresetn <= 1'b0;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        @(negedge hclk);
        chk(32'({pa, pb}), 32'h0);
        repeat (3) @(negedge hclk);
        chk(32'({pa, pb, mp}), 32'h0);
        chk(32'(cond), 32'(CDC_STEADY_RESET));
        @(posedge hclk);
        bus(1'b1, 8'h40, 32'hFFFFFFFF);
        bus(1'b0, 8'h40, 32'h0);
        chk(q, 32'h0);
        bus(1'b0, CDC_OFS_CONTROL, 32'h0);
        chk(q, {CDC_MOD_DEPTH_RESET, 11'h000, CDC_CTRL_RESET});
        bus(1'b0, CDC_OFS_STATUS, 32'h0);
        chk(q & 32'hFFFFFFFE, 32'({4'h1, envelope, 1'b0}));
        bus(1'b0, CDC_OFS_STEADY, 32'h0);
        chk(q, 32'h3F);
        bus(1'b0, CDC_OFS_MOD, 32'h0);
        chk(q, 32'h3F);
        $display("reset test done");
        give_verdict();
    end
endmodule // carrier_driver_control_test
